// *** hdl/aircc_decode.sv ***
// input code decoder for the converter multiplexer
`timescale 1ns/100ps
module aircc_decode
  import aircc_pkg::*;
(
  // code in
  input  wire logic [5:0]              code,
  // decoded selection
  output aircc_src_t                   src,
  output logic       [AIRCC_NPINS-1:0] pin_onehot
);
  // RQ1: code decode map
  always_comb begin
    pin_onehot = '0;
    if (code <= AIRCC_PIN_LAST) begin
      src = AIRCC_SRC_PIN;
      pin_onehot[code[4:0]] = 1'b1;
    end else if (code == AIRCC_CODE_TEMP) begin
      src = AIRCC_SRC_TEMP;
    end else if (code == AIRCC_CODE_VDD) begin
      src = AIRCC_SRC_VDD;
    end else if (code > AIRCC_CODE_VDD) begin
      src = AIRCC_SRC_GND;
    end else begin
      src = AIRCC_SRC_RSVD;
    end
  end
endmodule

// *** hdl/aircc_pkg.sv ***
// constants for converter input and reference control
// Functional notes
// RQ1: the six-bit input code in bits 5:0 picks port pins 0..24 in order, 110000 sensor, 110001 supply, 110010 and up ground, the rest reserved.
// RQ2: software uses codes 010010 through 011000 only on the larger package.
// RQ3: bits 7:6 of both registers read as zero and ignore writes.
// RQ4: software selects the sensor code before converting temperature.
// RQ5: with the sensor disabled its output floats and readings are meaningless.
// RQ6: reference control bit 2 powers the temperature sensor.
// RQ7: reference control bit 3 picks the reference, pin when zero, supply when one.
// RQ8: reference control bit 4 picks the internal level, 1.5 V when zero, 2.20 V when one.
// RQ9: the bias generator is on when any user needs it, or when bit 1 forces it.
// RQ10: bit 0 enables the reference buffer driving the reference pin.
// RQ11: software keeps the buffer off when the on-chip reference is unused.
// RQ12: bit 5 zero lets the zero-tc bias run on demand, one forces it on; set it before suspend.
// RQ13: reference control sits at register address 0xd1 on page 0x00.
// RQ14: channel select sits at register address 0xbb on page 0x00.
// RQ15: reset loads the channel code with all ones and clears reference control.
package aircc_pkg;
  localparam logic [7:0] AIRCC_CHSEL_ADDR  = 8'hbb;
  localparam logic [7:0] AIRCC_REFCTL_ADDR = 8'hd1;
  localparam logic [7:0] AIRCC_PAGE        = 8'h00;
  localparam logic [5:0] AIRCC_CHSEL_RST   = 6'h3f;
  localparam logic [5:0] AIRCC_REFCTL_RST  = 6'h00;
  localparam int         AIRCC_BIT_BUF     = 0;
  localparam int         AIRCC_BIT_BIAS    = 1;
  localparam int         AIRCC_BIT_TEMP    = 2;
  localparam int         AIRCC_BIT_SRC     = 3;
  localparam int         AIRCC_BIT_LVL     = 4;
  localparam int         AIRCC_BIT_ZTC     = 5;
  localparam logic [5:0] AIRCC_PIN_LAST    = 6'h18;
  localparam logic [5:0] AIRCC_CODE_TEMP   = 6'h30;
  localparam logic [5:0] AIRCC_CODE_VDD    = 6'h31;
  localparam int         AIRCC_NPINS       = 25;

  typedef enum logic [2:0] {
    AIRCC_SRC_PIN,
    AIRCC_SRC_TEMP,
    AIRCC_SRC_VDD,
    AIRCC_SRC_GND,
    AIRCC_SRC_RSVD
  } aircc_src_t;
endpackage

// *** hdl/aircc_top.sv ***
// channel select and reference control registers with analog steering
`timescale 1ns/100ps
module aircc_top
  import aircc_pkg::*;
(
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   srst,
  // special function register access
  input  wire logic [7:0]             sfr_addr,
  input  wire logic [7:0]             sfr_page,
  input  wire logic                   sfr_wr,
  input  wire logic                   sfr_rd,
  input  wire logic [7:0]             sfr_wdata,
  output logic      [7:0]             sfr_rdata,
  output logic                        sfr_hit,
  // bias demand from other analog users
  input  wire logic                   bias_demand,
  input  wire logic                   ztc_demand,
  // converter input multiplexer
  output logic      [AIRCC_NPINS-1:0] mux_pin_sel,
  output logic                        mux_temp_sel,
  output logic                        mux_vdd_sel,
  output logic                        mux_gnd_sel,
  output logic                        mux_reserved,
  // reference and bias controls
  output logic                        temp_sensor_on,
  output logic                        temp_sensor_hiz,
  output logic                        reference_source_select,
  output logic                        reference_level_select,
  output logic                        reference_buffer_on,
  output logic                        analog_bias_on,
  output logic                        zero_tc_bias_on
);
  // channel select state
  logic [5:0]             positive_input_code_r;
  logic [5:0]             positive_input_code_nxt;
  // reference control, one flop per field
  logic                   reference_buffer_on_r;
  logic                   analog_bias_force_on_r;
  logic                   temp_sensor_on_r;
  logic                   reference_source_select_r;
  logic                   reference_level_select_r;
  logic                   zero_tc_bias_force_on_r;
  logic [5:0]             reference_control_q;
  logic [5:0]             reference_control_nxt;
  // register access decode
  logic                   hit_chsel;
  logic                   hit_refctl;
  logic                   wr_chsel;
  logic                   wr_refctl;
  logic                   rd_chsel;
  logic                   rd_refctl;
  // read data
  logic [7:0]             sfr_rdata_r;
  logic [7:0]             sfr_rdata_nxt;
  // steering decoded one step ahead of the code flop
  aircc_src_t             src_nxt;
  logic [AIRCC_NPINS-1:0] pin_onehot_nxt;
  logic [AIRCC_NPINS-1:0] mux_pin_sel_r;
  logic                   mux_temp_sel_r;
  logic                   mux_vdd_sel_r;
  logic                   mux_gnd_sel_r;
  logic                   mux_reserved_r;
  // analog bias requests
  logic                   bias_users;

  // page and address match
  function automatic logic sfr_match(input logic [7:0] page, input logic [7:0] addr,
                                     input logic [7:0] target);
    sfr_match = (page == AIRCC_PAGE) && (addr == target);
  endfunction

  // RQ3: top bits read zero
  function automatic logic [7:0] pad_reg(input logic [5:0] v);
    pad_reg = {2'b00, v};
  endfunction

  // reset wins over a write in the same cycle
  function automatic logic [5:0] reg_next(input logic       rst,
                                          input logic       we,
                                          input logic [5:0] cur,
                                          input logic [5:0] wval,
                                          input logic [5:0] rstval);
    if (rst) begin
      reg_next = rstval;
    end else if (we) begin
      reg_next = wval;
    end else begin
      reg_next = cur;
    end
  endfunction

  // RQ13: reference control decode
  assign hit_refctl = sfr_match(sfr_page, sfr_addr, AIRCC_REFCTL_ADDR);
  // RQ14: channel select decode
  assign hit_chsel  = sfr_match(sfr_page, sfr_addr, AIRCC_CHSEL_ADDR);
  assign sfr_hit    = hit_chsel || hit_refctl;
  assign wr_chsel   = sfr_wr && hit_chsel;
  assign wr_refctl  = sfr_wr && hit_refctl;
  assign rd_chsel   = sfr_rd && hit_chsel;
  assign rd_refctl  = sfr_rd && hit_refctl;

  // RQ3: write ignores bits 7:6
  // RQ15: reset loads the ground code
  assign positive_input_code_nxt = reg_next(srst, wr_chsel, positive_input_code_r, sfr_wdata[5:0],
                                            AIRCC_CHSEL_RST);

  always_ff @(posedge clk) begin
    positive_input_code_r <= positive_input_code_nxt;
  end

  // RQ15: reference control cleared by reset
  assign reference_control_nxt = reg_next(srst, wr_refctl, reference_control_q, sfr_wdata[5:0],
                                          AIRCC_REFCTL_RST);

  // RQ10: buffer enable flop
  always_ff @(posedge clk) begin
    reference_buffer_on_r <= reference_control_nxt[AIRCC_BIT_BUF];
  end

  // RQ9: bias force flop
  always_ff @(posedge clk) begin
    analog_bias_force_on_r <= reference_control_nxt[AIRCC_BIT_BIAS];
  end

  // RQ6: sensor enable flop
  always_ff @(posedge clk) begin
    temp_sensor_on_r <= reference_control_nxt[AIRCC_BIT_TEMP];
  end

  // RQ7: reference source flop
  always_ff @(posedge clk) begin
    reference_source_select_r <= reference_control_nxt[AIRCC_BIT_SRC];
  end

  // RQ8: level select flop
  always_ff @(posedge clk) begin
    reference_level_select_r <= reference_control_nxt[AIRCC_BIT_LVL];
  end

  // RQ12: zero-tc force flop
  always_ff @(posedge clk) begin
    zero_tc_bias_force_on_r <= reference_control_nxt[AIRCC_BIT_ZTC];
  end

  // field flops gathered for read-back
  always_comb begin
    reference_control_q                 = '0;
    reference_control_q[AIRCC_BIT_BUF]  = reference_buffer_on_r;
    reference_control_q[AIRCC_BIT_BIAS] = analog_bias_force_on_r;
    reference_control_q[AIRCC_BIT_TEMP] = temp_sensor_on_r;
    reference_control_q[AIRCC_BIT_SRC]  = reference_source_select_r;
    reference_control_q[AIRCC_BIT_LVL]  = reference_level_select_r;
    reference_control_q[AIRCC_BIT_ZTC]  = zero_tc_bias_force_on_r;
  end

  // RQ3: read-back with zero top bits
  always_comb begin
    if (srst) begin
      sfr_rdata_nxt = 8'h00;
    end else if (rd_chsel) begin
      sfr_rdata_nxt = pad_reg(positive_input_code_r);
    end else if (rd_refctl) begin
      sfr_rdata_nxt = pad_reg(reference_control_q);
    end else begin
      // unmapped or idle reads give zero
      sfr_rdata_nxt = 8'h00;
    end
  end

  always_ff @(posedge clk) begin
    sfr_rdata_r <= sfr_rdata_nxt;
  end

  assign sfr_rdata = sfr_rdata_r;

  // RQ1: decode the code about to be stored
  aircc_decode u_decode (
    .code       (positive_input_code_nxt),
    .src        (src_nxt),
    .pin_onehot (pin_onehot_nxt)
  );

  // RQ1: steering flops track the code flop
  always_ff @(posedge clk) begin
    mux_pin_sel_r <= pin_onehot_nxt;
  end

  always_ff @(posedge clk) begin
    mux_temp_sel_r <= (src_nxt == AIRCC_SRC_TEMP);
  end

  always_ff @(posedge clk) begin
    mux_vdd_sel_r <= (src_nxt == AIRCC_SRC_VDD);
  end

  always_ff @(posedge clk) begin
    mux_gnd_sel_r <= (src_nxt == AIRCC_SRC_GND);
  end

  // reserved codes leave every switch open
  always_ff @(posedge clk) begin
    mux_reserved_r <= (src_nxt == AIRCC_SRC_RSVD);
  end

  assign mux_pin_sel  = mux_pin_sel_r;
  assign mux_temp_sel = mux_temp_sel_r;
  assign mux_vdd_sel  = mux_vdd_sel_r;
  assign mux_gnd_sel  = mux_gnd_sel_r;
  assign mux_reserved = mux_reserved_r;

  // RQ6: sensor power
  assign temp_sensor_on          = temp_sensor_on_r;
  // RQ5: sensor floats while off
  assign temp_sensor_hiz         = ~temp_sensor_on_r;
  // RQ7: reference source
  assign reference_source_select = reference_source_select_r;
  // RQ8: internal level select
  assign reference_level_select  = reference_level_select_r;
  // RQ10: buffer onto reference pin
  assign reference_buffer_on     = reference_buffer_on_r;

  // RQ9: bias on demand or forced
  // local users are the sensor and the buffer; others arrive on bias_demand
  assign bias_users     = bias_demand | temp_sensor_on_r | reference_buffer_on_r;
  assign analog_bias_on = analog_bias_force_on_r | bias_users;

  // RQ12: zero-tc bias forced or on demand
  // demand stays combinational so a waking user gets bias in its own cycle
  assign zero_tc_bias_on = zero_tc_bias_force_on_r | ztc_demand;
endmodule

// *** tb/aircc_top_sva.sv ***
// port assertions for converter input and reference control
`timescale 1ns/100ps
module aircc_top_sva (
  // clock, reset, register writes
  input wire logic       clk, srst, sfr_wr, sfr_hit,
  input wire logic [7:0] sfr_addr, sfr_page, sfr_wdata,
  // demands and analog controls
  input wire logic       bias_demand, ztc_demand, mux_temp_sel, mux_gnd_sel,
  input wire logic       temp_sensor_on, temp_sensor_hiz, reference_buffer_on, analog_bias_on,
  input wire logic       reference_source_select, reference_level_select, zero_tc_bias_on
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  sequence s_ref; sfr_wr && sfr_page == 8'h00 && sfr_addr == 8'hd1; endsequence
  sequence s_chn; sfr_wr && sfr_page == 8'h00 && sfr_addr == 8'hbb; endsequence
  a_reset_gnd: assert property ($past(srst) |-> mux_gnd_sel && !temp_sensor_on)
    else $error("reset state wrong");
  a_hiz_inverse: assert property (temp_sensor_hiz != temp_sensor_on)
    else $error("sensor float wrong");
  a_bias_auto: assert property ((bias_demand || temp_sensor_on || reference_buffer_on) |-> analog_bias_on)
    else $error("bias off");
  a_ztc_auto: assert property (ztc_demand |-> zero_tc_bias_on)
    else $error("zero tc bias off");
  a_temp_write: assert property (s_ref |=> temp_sensor_on == $past(sfr_wdata[2]))
    else $error("sensor enable wrong");
  a_src_write: assert property (s_ref |=> reference_source_select == $past(sfr_wdata[3]))
    else $error("reference source wrong");
  a_lvl_write: assert property (s_ref |=> reference_level_select == $past(sfr_wdata[4]))
    else $error("reference level wrong");
  a_temp_chan: assert property (s_chn ##0 sfr_wdata[5:0] == 6'h30 |=> mux_temp_sel)
    else $error("sensor channel wrong");
  a_gnd_chan: assert property (s_chn ##0 sfr_wdata[5:0] >= 6'h32 |=> mux_gnd_sel)
    else $error("ground channel wrong");
  a_buf_write: assert property (s_ref |=> reference_buffer_on == $past(sfr_wdata[0]))
    else $error("buffer enable wrong");
  a_bias_force: assert property (s_ref ##0 sfr_wdata[1] |=> analog_bias_on)
    else $error("bias force ignored");
  a_ztc_force: assert property (s_ref ##0 sfr_wdata[5] |=> zero_tc_bias_on)
    else $error("zero tc force ignored");
  a_hit_decode: assert property (sfr_hit == (sfr_page == 8'h00 && (sfr_addr == 8'hbb || sfr_addr == 8'hd1)))
    else $error("register hit wrong");
endmodule
bind aircc_top aircc_top_sva i_sva (.clk, .srst, .sfr_wr, .sfr_hit, .sfr_addr, .sfr_page, .sfr_wdata, .bias_demand,
  .ztc_demand, .mux_temp_sel, .mux_gnd_sel, .temp_sensor_on, .temp_sensor_hiz, .reference_buffer_on,
  .analog_bias_on, .reference_source_select, .reference_level_select, .zero_tc_bias_on);

// *** tb/aircc_top_tb.sv ***
// self-checking bench for converter input and reference control
`timescale 1ns/100ps
module aircc_top_tb;
  import aircc_pkg::*;
  `define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin miscompares++; $display("[ERR] %0t %h %h", $time, g, e); end end
  logic clk = 0, srst = 1, sfr_wr = 0, sfr_rd = 0, rd_d = 0, bias_demand = 0, ztc_demand = 0;
  logic [7:0] sfr_addr = 0, sfr_page = 0, sfr_wdata = 0, sfr_rdata, v;
  logic [AIRCC_NPINS-1:0] mux_pin_sel;
  logic mux_temp_sel, mux_vdd_sel, mux_gnd_sel, mux_reserved;
  logic [5:0] code = 6'h3f;
  logic [31:0] r = 32'h6bbc8e82;
  logic [36:0] q[$], e;
  int miscompares = 0, n_compared = 0;
  aircc_top i_aircc_top (.clk, .srst, .sfr_addr, .sfr_page, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata, .sfr_hit(),
    .bias_demand, .ztc_demand, .mux_pin_sel, .mux_temp_sel, .mux_vdd_sel, .mux_gnd_sel, .mux_reserved,
    .temp_sensor_on(), .temp_sensor_hiz(), .reference_source_select(), .reference_level_select(),
    .reference_buffer_on(), .analog_bias_on(), .zero_tc_bias_on());
  initial forever #4 clk = ~clk;
  function automatic logic [31:0] nx(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // read data plus the whole decoded selection
  function automatic logic [36:0] ex(logic [7:0] x);
    return {x, code == 6'h30, code == 6'h31, code >= 6'h32, code > 6'h18 && code < 6'h30, 25'(code <= 6'h18) << code};
  endfunction
  always @(posedge clk) begin
    rd_d <= sfr_rd;
    if (rd_d) begin
      e = q.pop_front();
      `CHK({sfr_rdata, mux_temp_sel, mux_vdd_sel, mux_gnd_sel, mux_reserved, mux_pin_sel}, e)
    end
  end
  // one access; demand inputs wander so the bias checks see traffic
  task automatic acc(logic w, logic [7:0] a, p, d, x);
    @(posedge clk);
    {sfr_wr, sfr_rd, sfr_addr, sfr_page, sfr_wdata} <= {w, !w, a, p, d};
    r = nx(r);
    {bias_demand, ztc_demand} <= r[1:0];
    if (w && p == 8'h00 && a == 8'hbb) code = d[5:0];
    if (!w) q.push_back(ex(x));
    @(posedge clk);
    {sfr_wr, sfr_rd} <= 2'b00;
  endtask
  task automatic summarize;
    $display("compared %0d, mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    srst <= 0;
    acc(0, 8'hbb, 0, 0, 8'h3f);
    acc(0, 8'hd1, 0, 0, 0);
    $display("reset test done");
    // codes 0x12 to 0x18 driven as on the larger package
    for (int i = 0; i < 64; i++) begin
      acc(1, 8'hbb, 0, {r[7:6], 6'(i)}, 0);
      acc(0, 8'hbb, 0, 0, {2'b00, 6'(i)});
    end
    $display("channel test done");
    for (int i = 0; i < 17; i++) begin
      v = i ? r[15:8] : 8'hff;
      acc(1, 8'hd1, 0, v, 0);
      acc(0, 8'hd1, 0, 0, v & 8'h3f);
    end
    $display("reference test done");
    // off-page and unmapped places stay silent
    acc(1, 8'hbb, 8'h01, 8'h00, 0);
    acc(0, 8'hbb, 8'h01, 0, 0);
    acc(0, 8'hc0, 0, 0, 0);
    acc(0, 8'hbb, 0, 0, {2'b00, code});
    $display("refusal test done");
    // leave a busy state behind, then reset in mid-run
    acc(1, 8'hbb, 0, 8'h30, 0);
    acc(1, 8'hd1, 0, 8'h20, 0);
    acc(0, 8'hd1, 0, 0, 8'h20);
    srst <= 1;
    code = 6'h3f;
    repeat (2) @(posedge clk);
    srst <= 0;
    acc(0, 8'hbb, 0, 0, 8'h3f);
    acc(0, 8'hd1, 0, 0, 0);
    $display("second reset test done");
    for (int i = 0; i < 8 && q.size() > 0; i++) @(posedge clk);
    if (q.size() > 0) miscompares++;
    summarize();
  end
endmodule
